// *** awd_window_wdg.sv ***
`timescale 1ns/1ps
`default_nettype none
module awd_window_wdg #(
    parameter int TICK_CYCLES     = awd_pkg::TICK_CYCLES,
    parameter int INIT_TIMEOUT_MS = awd_pkg::INIT_TIMEOUT_MS
) (
    input  wire logic       sys_clk_in,
    input  wire logic       nrst_in,
    input  wire logic       normal_mode_in,
    input  wire logic       stop_mode_in,
    input  wire logic       high_test_voltage_in,
    input  wire logic       test_n_in,
    input  wire logic       reg_wr_in,
    input  wire logic       reg_rd_in,
    input  wire logic [7:0] reg_addr_in,
    input  wire logic [7:0] reg_wdata_in,
    output logic      [7:0] reg_rdata_out,
    output logic            wdg_reset_out
);
    localparam int CW = awd_pkg::CNT_W;
    localparam logic [CW-1:0] INIT_TICKS =
        CW'(INIT_TIMEOUT_MS * awd_pkg::TICKS_PER_MS);
    localparam logic [CW-1:0] BASE_TICKS =
        CW'(awd_pkg::BASE_PERIOD_MS * awd_pkg::TICKS_PER_MS);

    // every code doubles, so 110 lands on 640 ms and 111 on 1280 ms
    function automatic logic [CW-1:0] period_ticks(input logic [2:0] sel);
        period_ticks = BASE_TICKS << sel; // RL3 RL19
    endfunction

    awd_pkg::awd_state_e state_reg;
    awd_pkg::awd_state_e state_next;
    logic [CW-1:0] cnt_reg;
    logic [CW-1:0] cnt_next;
    logic [7:0]    expect_reg;
    logic [7:0]    expect_next;
    logic [2:0]    period_select_reg;
    logic [2:0]    period_select_next;
    logic [2:0]    per_act_reg;
    logic [2:0]    per_act_next;
    logic          stop_rd_reg;
    logic          stop_rd_next;
    logic          rst_pulse_reg;
    logic          rst_pulse_next;
    logic [7:0]    rdata_reg;
    logic [7:0]    rdata_next;

    logic [1:0]    pins_sync;
    logic          dbg_off;
    logic          tick;
    logic          cfg_wr;
    logic          cfg_rd;
    logic          svc_wr;
    logic [CW-1:0] cur_period;
    logic          window_open_flag;
    logic          wdg_disabled_flag;
    logic [7:0]    cfg_read_val;
    logic          fault;

    awd_sync3 #(
        .W (2)
    ) u_pin_sync (
        .sys_clk_in (sys_clk_in),
        .nrst_in    (nrst_in),
        .async_in   ({high_test_voltage_in, test_n_in}),
        .level_out  (pins_sync)
    );

    // debug disable: high test voltage present while the test pin is grounded
    assign dbg_off = pins_sync[1] & ~pins_sync[0]; // RL13

    // the oscillator stands still outside Normal mode and under debug disable
    awd_tick_gen #(
        .DIV (TICK_CYCLES)
    ) u_tick (
        .sys_clk_in (sys_clk_in),
        .nrst_in    (nrst_in),
        .run_in     (normal_mode_in & ~dbg_off), // RL1 RL2
        .tick_out   (tick)
    );

    assign cfg_wr = reg_wr_in && (reg_addr_in == awd_pkg::CFG_OFFSET);
    assign cfg_rd = reg_rd_in && (reg_addr_in == awd_pkg::CFG_OFFSET);
    assign svc_wr = reg_wr_in && (reg_addr_in == awd_pkg::SVC_OFFSET);

    assign cur_period = period_ticks(per_act_reg);
    assign window_open_flag = (state_reg == awd_pkg::ST_INIT) || // RL5
        ((state_reg == awd_pkg::ST_WIN) && (cnt_reg >= (cur_period >> 1))); // RL9 RL11
    assign wdg_disabled_flag = dbg_off | stop_rd_reg; // RL4 RL13

    always_comb begin
        cfg_read_val = awd_pkg::CFG_RESET; // RL17
        cfg_read_val[awd_pkg::DISABLED_BIT] = wdg_disabled_flag;
        cfg_read_val[awd_pkg::OPEN_BIT]     = window_open_flag; // RL11
        cfg_read_val[awd_pkg::SEL_MSB:0]    = period_select_reg;
    end

    always_comb begin
        state_next         = state_reg;
        cnt_next           = cnt_reg;
        expect_next        = expect_reg;
        period_select_next = period_select_reg;
        per_act_next       = per_act_reg;
        stop_rd_next       = stop_rd_reg;
        rst_pulse_next     = 1'b0;
        rdata_next         = rdata_reg;
        fault              = 1'b0;

        // held in the register only; the running timeout picks it up later
        if (cfg_wr) begin
            period_select_next = reg_wdata_in[awd_pkg::SEL_MSB:0]; // RL6
        end
        if (cfg_rd) begin
            rdata_next = cfg_read_val;
        end else if (reg_rd_in) begin
            rdata_next = 8'h00;
        end
        // a Normal-mode read of the config register clears the stop mark;
        // a Stop-mode read sets it, and the set wins
        if (cfg_rd && normal_mode_in) begin
            stop_rd_next = 1'b0;
        end
        if (reg_rd_in && stop_mode_in) begin
            stop_rd_next = 1'b1; // RL4
        end

        if (dbg_off) begin
            state_next  = awd_pkg::ST_OFF; // RL13 RL14
            cnt_next    = '0;
            expect_next = awd_pkg::CODE_FIRST; // RL14 RL16
        end else if (!normal_mode_in) begin
            // counter frozen, sequence restarts with the first code
            expect_next = awd_pkg::CODE_FIRST; // RL1 RL15
            if (state_reg == awd_pkg::ST_OFF) begin
                state_next = awd_pkg::ST_INIT;
            end
        end else begin
            unique case (state_reg)
                awd_pkg::ST_OFF: begin
                    state_next  = awd_pkg::ST_INIT; // RL14
                    cnt_next    = '0;
                    expect_next = awd_pkg::CODE_FIRST;
                end
                awd_pkg::ST_INIT: begin
                    if (svc_wr) begin
                        if (reg_wdata_in == awd_pkg::CODE_FIRST) begin // RL7
                            state_next   = awd_pkg::ST_WIN;
                            cnt_next     = '0;
                            expect_next  = awd_pkg::CODE_SECOND;
                            per_act_next = period_select_reg;
                        end else begin
                            fault = 1'b1; // RL8
                        end
                    end else if (tick) begin
                        if (cnt_reg == INIT_TICKS - 1'b1) begin
                            fault = 1'b1; // RL5 RL8
                        end else begin
                            cnt_next = cnt_reg + 1'b1;
                        end
                    end
                end
                awd_pkg::ST_WIN: begin
                    if (svc_wr) begin
                        if (window_open_flag && reg_wdata_in == expect_reg) begin // RL9 RL10
                            cnt_next     = '0;
                            expect_next  = (expect_reg == awd_pkg::CODE_FIRST) ?
                                awd_pkg::CODE_SECOND : awd_pkg::CODE_FIRST;
                            per_act_next = period_select_reg;
                        end else begin
                            fault = 1'b1; // RL12
                        end
                    end else if (tick) begin
                        if (cnt_reg == cur_period - 1'b1) begin
                            fault = 1'b1; // RL3 RL12
                        end else begin
                            cnt_next = cnt_reg + 1'b1;
                        end
                    end
                end
                default: begin
                    state_next = awd_pkg::ST_INIT;
                end
            endcase
            if (fault) begin
                rst_pulse_next = 1'b1; // RL18
                state_next     = awd_pkg::ST_INIT;
                cnt_next       = '0;
                expect_next    = awd_pkg::CODE_FIRST;
            end
        end
    end

    always_ff @(posedge sys_clk_in) begin
        if (!nrst_in) begin
            state_reg         <= awd_pkg::ST_INIT;
            cnt_reg           <= '0;
            expect_reg        <= awd_pkg::CODE_FIRST;
            period_select_reg <= awd_pkg::SEL_RESET; // RL17
            per_act_reg       <= awd_pkg::SEL_RESET;
            stop_rd_reg       <= 1'b0;
            rst_pulse_reg     <= 1'b0;
            rdata_reg         <= 8'h00;
        end else begin
            state_reg         <= state_next;
            cnt_reg           <= cnt_next;
            expect_reg        <= expect_next;
            period_select_reg <= period_select_next;
            per_act_reg       <= per_act_next;
            stop_rd_reg       <= stop_rd_next;
            rst_pulse_reg     <= rst_pulse_next;
            rdata_reg         <= rdata_next;
        end
    end

    assign reg_rdata_out = rdata_reg;
    assign wdg_reset_out = rst_pulse_reg;

    // ---------------- assertions ----------------
    default clocking cb @(posedge sys_clk_in);
    endclocking
    default disable iff (!nrst_in);

    property p_lowpower_frozen;
        (!normal_mode_in && !dbg_off) |=> $stable(cnt_reg) && !wdg_reset_out;
    endproperty
    a_lowpower_frozen: assert property (p_lowpower_frozen) // RL1
        else $error("counter moved outside Normal mode");

    property p_count_on_tick;
        (state_reg == awd_pkg::ST_WIN && !tick && !svc_wr && !dbg_off)
            |=> $stable(cnt_reg);
    endproperty
    a_count_on_tick: assert property (p_count_on_tick) // RL2
        else $error("counter advanced without an oscillator tick");

    property p_window_expiry;
        (normal_mode_in && !dbg_off && state_reg == awd_pkg::ST_WIN && tick && !svc_wr
            && cnt_reg == period_ticks(per_act_reg) - 1'b1)
            |=> wdg_reset_out && state_reg == awd_pkg::ST_INIT;
    endproperty
    a_window_expiry: assert property (p_window_expiry) // RL3
        else $error("window period expired without reset");

    property p_stop_read;
        (reg_rd_in && stop_mode_in) |=> wdg_disabled_flag;
    endproperty
    a_stop_read: assert property (p_stop_read) // RL4
        else $error("stop-mode read did not set disabled flag");

    property p_init_open;
        (state_reg == awd_pkg::ST_INIT) |-> window_open_flag;
    endproperty
    a_init_open: assert property (p_init_open) // RL5
        else $error("window-open flag low in initial phase");

    property p_init_fixed;
        (normal_mode_in && !dbg_off && state_reg == awd_pkg::ST_INIT && tick && !svc_wr
            && cnt_reg == INIT_TICKS - 1'b1) |=> wdg_reset_out;
    endproperty
    a_init_fixed: assert property (p_init_fixed) // RL6
        else $error("initial timeout not fixed");

    property p_bad_first;
        (normal_mode_in && !dbg_off && state_reg == awd_pkg::ST_INIT && svc_wr
            && reg_wdata_in != awd_pkg::CODE_FIRST) |=> wdg_reset_out;
    endproperty
    a_bad_first: assert property (p_bad_first) // RL8
        else $error("wrong first service code accepted");

    property p_closed_window;
        (normal_mode_in && !dbg_off && state_reg == awd_pkg::ST_WIN && svc_wr
            && cnt_reg < (period_ticks(per_act_reg) >> 1)) |=> wdg_reset_out;
    endproperty
    a_closed_window: assert property (p_closed_window) // RL9
        else $error("service accepted in closed window");

    property p_open_flag;
        (state_reg == awd_pkg::ST_WIN)
            |-> (window_open_flag == (cnt_reg >= (period_ticks(per_act_reg) >> 1)));
    endproperty
    a_open_flag: assert property (p_open_flag) // RL11
        else $error("window-open flag wrong");

    property p_wrong_code;
        (normal_mode_in && !dbg_off && state_reg == awd_pkg::ST_WIN && svc_wr
            && reg_wdata_in != expect_reg) |=> wdg_reset_out ##1 !wdg_reset_out;
    endproperty
    a_wrong_code: assert property (p_wrong_code) // RL12 RL18
        else $error("wrong service code not punished by one pulse");

    property p_debug_off;
        dbg_off |=> state_reg == awd_pkg::ST_OFF && expect_reg == awd_pkg::CODE_FIRST
            && !wdg_reset_out;
    endproperty
    a_debug_off: assert property (p_debug_off) // RL13 RL14 RL16
        else $error("debug disable not honoured");

    property p_disabled_bit;
        (cfg_rd && dbg_off) |=> reg_rdata_out[awd_pkg::DISABLED_BIT];
    endproperty
    a_disabled_bit: assert property (p_disabled_bit) // RL13
        else $error("disabled bit not shown");

    property p_reserved_zero;
        cfg_rd |=> reg_rdata_out[5:3] == 3'h0;
    endproperty
    a_reserved_zero: assert property (p_reserved_zero) // RL17
        else $error("reserved config bits not zero");

    property p_lowpower_seq;
        (!normal_mode_in && !dbg_off) |=> expect_reg == awd_pkg::CODE_FIRST;
    endproperty
    a_lowpower_seq: assert property (p_lowpower_seq) // RL15
        else $error("service sequence not restarted in low power");

    c_enter_window: cover property (state_reg == awd_pkg::ST_INIT ##1
        state_reg == awd_pkg::ST_WIN);
    c_good_service: cover property (state_reg == awd_pkg::ST_WIN && svc_wr
        && window_open_flag && reg_wdata_in == expect_reg);
    c_reset_pulse: cover property (wdg_reset_out);
    c_debug_exit: cover property (state_reg == awd_pkg::ST_OFF ##1
        state_reg == awd_pkg::ST_INIT);
endmodule // awd_window_wdg
`default_nettype wire

// *** awd_pkg.sv ***
// Functional notes
// [RL1] count only in Normal mode, halted otherwise
// [RL2] counter runs from own oscillator tick
// [RL3] period select: 10 ms doubling, 111 1280 ms
// [RL4] bus read during Stop sets disabled flag
// [RL5] initial fixed timeout, window-open flag held set
// [RL6] period writes during initial phase not applied
// [RL7] first service write must be 0xAA
// [RL8] initial expiry or wrong first code resets
// [RL9] no counter reset in first half
// [RL10] host alternates 0x55/0xAA in second half
// [RL11] window-open flag bit 6 shows permission
// [RL12] window expiry or wrong code resets
// [RL13] debug pin condition disables, bit 7 set
// [RL14] disable clears service state; restart initial phase
// [RL15] low power entry clears service sequence
// [RL16] service writes while disabled are ignored
// [RL17] bits 5..3 read zero, reset all zero
// [RL18] watchdog reset is one pulse, back to initial
// [RL19] code 110 is the 640 ms doubling step
package awd_pkg;
    localparam logic [7:0] CFG_OFFSET     = 8'h10;
    localparam logic [7:0] SVC_OFFSET     = 8'h11;
    localparam logic [7:0] CFG_RESET      = 8'h00;
    localparam int         DISABLED_BIT   = 7;
    localparam int         OPEN_BIT       = 6;
    localparam int         SEL_MSB        = 2;
    localparam logic [2:0] SEL_RESET      = 3'h0;
    localparam logic [7:0] CODE_FIRST     = 8'hAA;
    localparam logic [7:0] CODE_SECOND    = 8'h55;
    localparam int         CLK_PERIOD_NS  = 40;
    localparam int         TICK_NS        = 500000;
    localparam int         TICK_CYCLES    = TICK_NS / CLK_PERIOD_NS;
    localparam int         TICKS_PER_MS   = 1000000 / TICK_NS;
    localparam int         BASE_PERIOD_MS = 10;
    localparam int         INIT_TIMEOUT_MS = 256;
    localparam int         CNT_W          = 12;
    typedef enum logic [1:0] {ST_OFF, ST_INIT, ST_WIN} awd_state_e;
endpackage

// *** awd_tick_gen.sv ***
`timescale 1ns/1ps
`default_nettype none
// stands in for the separate watchdog oscillator: a divider on the one clock
module awd_tick_gen #(
    parameter int DIV = 12500
) (
    input  wire logic sys_clk_in,
    input  wire logic nrst_in,
    input  wire logic run_in,
    output logic      tick_out
);
    localparam int W = $clog2(DIV);
    logic [W-1:0] div_reg;
    logic [W-1:0] div_next;
    logic         tick_next;
    logic         tick_reg;

    always_comb begin
        div_next  = div_reg;
        tick_next = 1'b0;
        if (run_in) begin
            if (div_reg == W'(DIV - 1)) begin
                div_next  = '0;
                tick_next = 1'b1;
            end else begin
                div_next = div_reg + 1'b1;
            end
        end
    end

    always_ff @(posedge sys_clk_in) begin
        if (!nrst_in) begin
            div_reg  <= '0;
            tick_reg <= 1'b0;
        end else begin
            div_reg  <= div_next;
            tick_reg <= tick_next;
        end
    end

    assign tick_out = tick_reg;
endmodule // awd_tick_gen
`default_nettype wire

// *** awd_sync3.sv ***
`timescale 1ns/1ps
`default_nettype none
module awd_sync3 #(
    parameter int W = 1
) (
    input  wire logic         sys_clk_in,
    input  wire logic         nrst_in,
    input  wire logic [W-1:0] async_in,
    output logic      [W-1:0] level_out
);
    logic [W-1:0] s1_reg;
    logic [W-1:0] s2_reg;
    logic [W-1:0] s3_reg;
    logic [W-1:0] lvl_reg;
    logic [W-1:0] lvl_next;

    // a bit changes only once stages two and three agree
    always_comb begin
        for (int i = 0; i < W; i++) begin
            lvl_next[i] = (s2_reg[i] == s3_reg[i]) ? s3_reg[i] : lvl_reg[i];
        end
    end

    always_ff @(posedge sys_clk_in) begin
        if (!nrst_in) begin
            s1_reg  <= '0;
            s2_reg  <= '0;
            s3_reg  <= '0;
            lvl_reg <= '0;
        end else begin
            s1_reg  <= async_in;
            s2_reg  <= s1_reg;
            s3_reg  <= s2_reg;
            lvl_reg <= lvl_next;
        end
    end

    assign level_out = lvl_reg;
endmodule // awd_sync3
`default_nettype wire

// *** awd_host_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module awd_host_model (
    input  wire logic       sys_clk_in,
    output logic            reg_wr_out,
    output logic            reg_rd_out,
    output logic [7:0]      reg_addr_out,
    output logic [7:0]      reg_wdata_out,
    input  wire logic [7:0] reg_rdata_in
);
    logic [7:0] next_code;

    initial begin
        reg_wr_out = 1'b0;
        reg_rd_out = 1'b0;
        reg_addr_out = 8'h00;
        reg_wdata_out = 8'h00;
        next_code = awd_pkg::CODE_FIRST;
    end

    task automatic write_reg(input logic [7:0] addr, input logic [7:0] data);
        @(negedge sys_clk_in);
        reg_addr_out = addr;
        reg_wdata_out = data;
        reg_wr_out = 1'b1;
        @(negedge sys_clk_in);
        reg_wr_out = 1'b0;
        // released lines must not look like a held request
        reg_addr_out = ~addr;
        reg_wdata_out = ~data;
    endtask

    task automatic read_reg(input logic [7:0] addr, output logic [7:0] data);
        @(negedge sys_clk_in);
        reg_addr_out = addr;
        reg_rd_out = 1'b1;
        @(negedge sys_clk_in);
        data = reg_rdata_in;
        reg_rd_out = 1'b0;
        reg_addr_out = ~addr;
    endtask

    task automatic restart_sequence();
        next_code = awd_pkg::CODE_FIRST;
    endtask

    task automatic service();
        write_reg(awd_pkg::SVC_OFFSET, next_code);
        next_code = (next_code == awd_pkg::CODE_FIRST) ? awd_pkg::CODE_SECOND
                                                      : awd_pkg::CODE_FIRST;
    endtask
endmodule // awd_host_model
`default_nettype wire

// *** test_analog_die_window_watchdog.sv ***
`timescale 1ns/1ps
`default_nettype none
module test_analog_die_window_watchdog;
    localparam int TCK = 4;
    localparam int INIT_MS = 2;
    localparam int INIT_CYC = INIT_MS * 2 * TCK;
    localparam logic [7:0] CFG = awd_pkg::CFG_OFFSET;
    localparam logic [7:0] SVC = awd_pkg::SVC_OFFSET;
    logic       sys_clk_in;
    logic       nrst_in;
    logic       normal_mode_in;
    logic       stop_mode_in;
    logic       high_test_voltage_in;
    logic       test_n_in;
    logic       reg_wr;
    logic       reg_rd;
    logic [7:0] reg_addr;
    logic [7:0] reg_wdata;
    logic [7:0] reg_rdata;
    logic       wdg_reset;
    logic       prev_rst = 1'b0;
    logic [7:0] lfsr = 8'h3F;
    logic [7:0] rd;
    logic [2:0] sel;
    int         n_errors = 0;
    int         num_checks = 0;
    int         n_pulses = 0;
    int         p0;
    int         took;
    int         per;

    awd_window_wdg #(.TICK_CYCLES(TCK), .INIT_TIMEOUT_MS(INIT_MS)) uut (
        .sys_clk_in          (sys_clk_in),
        .nrst_in             (nrst_in),
        .normal_mode_in      (normal_mode_in),
        .stop_mode_in        (stop_mode_in),
        .high_test_voltage_in(high_test_voltage_in),
        .test_n_in           (test_n_in),
        .reg_wr_in           (reg_wr),
        .reg_rd_in           (reg_rd),
        .reg_addr_in         (reg_addr),
        .reg_wdata_in        (reg_wdata),
        .reg_rdata_out       (reg_rdata),
        .wdg_reset_out       (wdg_reset)
    );

    awd_host_model host (
        .sys_clk_in   (sys_clk_in),
        .reg_wr_out   (reg_wr),
        .reg_rd_out   (reg_rd),
        .reg_addr_out (reg_addr),
        .reg_wdata_out(reg_wdata),
        .reg_rdata_in (reg_rdata)
    );

    initial begin
        sys_clk_in = 1'b0;
        forever #20 sys_clk_in = ~sys_clk_in;
    end

    function automatic logic [7:0] next_rand(input logic [7:0] v);
        return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
    endfunction

    function automatic int period_cycles(input logic [2:0] s);
        return (20 << s) * TCK;
    endfunction

    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        num_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic give_verdict();
        $display("checks %0d errors %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    // counts cycles until the next reset pulse, giving up after max
    task automatic wait_pulse(input int max, output int cnt);
        int p;
        p = n_pulses;
        cnt = 0;
        while (n_pulses == p && cnt < max) begin
            @(negedge sys_clk_in);
            cnt++;
        end
    endtask

    task automatic quiet(input int cycles, input string what);
        p0 = n_pulses;
        repeat (cycles) @(negedge sys_clk_in);
        check(what, 16'(n_pulses - p0), 16'h0000);
    endtask

    // counted on the rising edge so that the falling-edge tasks never race the count
    always @(posedge sys_clk_in) begin
        if (wdg_reset === 1'b1) begin
            n_pulses++;
            check("reset pulse width", {15'h0000, prev_rst}, 16'h0000);
        end
        prev_rst = wdg_reset;
    end

    initial begin
        #1000000;
        n_errors++;
        give_verdict();
    end

    initial begin
        nrst_in = 1'b0;
        normal_mode_in = 1'b1;
        stop_mode_in = 1'b0;
        high_test_voltage_in = 1'b0;
        test_n_in = 1'b1;
        repeat (20) @(negedge sys_clk_in);
        nrst_in = 1'b1;
        host.read_reg(CFG, rd);
        check("cfg after reset", {8'h00, rd}, 16'h0040);
        wait_pulse(INIT_CYC + 8, took);
        check("initial expiry", 16'(took + 2 >= INIT_CYC - TCK && took < INIT_CYC + 8), 16'h0001);
        for (int i = 0; i < 3; i++) begin
            lfsr = next_rand(lfsr);
            host.write_reg(CFG, {5'h1F, lfsr[2:0]});
            host.read_reg(CFG, rd);
            check("cfg readback", {8'h00, rd}, {8'h00, 5'b01000, lfsr[2:0]});
            wait_pulse(INIT_CYC + 8, took);
            check("initial timeout kept", 16'(took + 4 >= INIT_CYC - TCK && took < INIT_CYC + 8), 16'h0001);
        end
        for (int i = 0; i < 3; i++) begin
            lfsr = next_rand(lfsr);
            host.write_reg(SVC, (lfsr == 8'hAA) ? 8'h55 : lfsr);
            wait_pulse(4, took);
            check("wrong first code", 16'(took < 4), 16'h0001);
        end
        for (int k = 0; k < 4; k++) begin
            sel = (k < 2) ? 3'(k) : 3'(k + 4);
            per = period_cycles(sel);
            host.write_reg(CFG, {5'h00, sel});
            host.restart_sequence();
            host.service();
            host.read_reg(CFG, rd);
            check("window entered", {8'h00, rd}, {8'h00, 5'b00000, sel});
            wait_pulse(per + TCK + 4, took);
            check("window expiry", 16'(took + 2 >= per - TCK && took + 2 <= per + TCK + 2), 16'h0001);
        end
        per = period_cycles(3'h0);
        host.write_reg(CFG, 8'h00);
        host.restart_sequence();
        host.service();
        host.service();
        wait_pulse(4, took);
        check("early service", 16'(took < 4), 16'h0001);
        host.restart_sequence();
        host.service();
        for (int i = 0; i < 3; i++) begin
            repeat (per / 2 + 2 * TCK) @(negedge sys_clk_in);
            host.read_reg(CFG, rd);
            check("window open", {15'h0000, rd[6]}, 16'h0001);
            host.service();
            quiet(3, "good service");
        end
        repeat (per / 2 + 2 * TCK) @(negedge sys_clk_in);
        host.write_reg(SVC, 8'h55);
        wait_pulse(4, took);
        check("wrong window code", 16'(took < 4), 16'h0001);
        host.restart_sequence();
        host.service();
        // low power entered while 0x55 is due: only a restarted sequence takes 0xAA after it
        normal_mode_in = 1'b0;
        quiet(400, "low power halt");
        normal_mode_in = 1'b1;
        host.restart_sequence();
        repeat (per / 2 + 2 * TCK) @(negedge sys_clk_in);
        host.service();
        quiet(3, "sequence restart");
        high_test_voltage_in = 1'b1;
        test_n_in = 1'b0;
        repeat (6) @(negedge sys_clk_in);
        host.read_reg(CFG, rd);
        check("disabled flag", {15'h0000, rd[7]}, 16'h0001);
        host.write_reg(SVC, 8'h55);
        quiet(200, "disabled quiet");
        high_test_voltage_in = 1'b0;
        test_n_in = 1'b1;
        repeat (6) @(negedge sys_clk_in);
        host.read_reg(CFG, rd);
        check("reenable open", {15'h0000, rd[6]}, 16'h0001);
        wait_pulse(INIT_CYC + 8, took);
        check("reenable initial", 16'(took < INIT_CYC + 8), 16'h0001);
        normal_mode_in = 1'b0;
        stop_mode_in = 1'b1;
        host.read_reg(SVC, rd);
        stop_mode_in = 1'b0;
        normal_mode_in = 1'b1;
        host.read_reg(CFG, rd);
        check("stop read flag", {15'h0000, rd[7]}, 16'h0001);
        host.read_reg(CFG, rd);
        check("stop flag cleared", {15'h0000, rd[7]}, 16'h0000);
        give_verdict();
    end
endmodule // test_analog_die_window_watchdog
`default_nettype wire
